/* hdl/load_seq_pkg.sv */
// Purpose: constants and types shared by the generator load mode sequencer
// Assumes: 100 MHz pclk, APB register access, 16-bit load quantities
// Notes:   What this block does
//
// What this block does
// - breaker open: droop only, contacts ignored
// - breaker closed: honour base and unload contacts
// - base and unload closed: base load
// - unload only closed: isochronous load sharing
// - breaker closes: ramp load up linearly
// - stop soft ramp when load equals share
// - unload opens: ramp down to trip level
// - trip level in sharing: pulse breaker-open relay
// - utility trip: relay momentarily de-energised
// - base load entry: ramp to base setting
// - raise/lower move base target, rated follow
// - both closed, external above minimum: use it
// - breaker opens: drop bias, reset loading
// - base from sharing ignores other units
// - base opens: ramp to share, stop ramps
// - droop lowers speed as load rises
// - power loss restores last saved settings
package load_seq_pkg;

  // ***********************************************
  // clocking and control tick
  // ***********************************************
  localparam int CLK_NS        = 10;    // pclk period
  localparam int TICK_NS       = 1000;  // control cycle period
  localparam int TICK_CYCLES   = TICK_NS / CLK_NS;
  localparam int TICK_W        = 8;

  // ***********************************************
  // data widths
  // ***********************************************
  localparam int LOAD_W        = 16;    // load and set point width
  localparam int SET_N         = 7;     // number of stored settings
  localparam int SET_AW        = 3;     // setting index width
  localparam int PAW           = 8;     // apb address width

  // ***********************************************
  // register byte offsets
  // ***********************************************
  localparam logic [PAW-1:0] CTRL_OFS   = 8'h00; // control, save
  localparam logic [PAW-1:0] STATUS_OFS = 8'h04; // mode and contacts
  localparam logic [PAW-1:0] LREF_OFS   = 8'h08; // ramped load reference
  localparam logic [PAW-1:0] DROOP_OFS  = 8'h0C; // droop term
  localparam logic [PAW-1:0] SET0_OFS   = 8'h10; // first setting word

  // setting word indices
  localparam logic [SET_AW-1:0] S_BASE   = 3'h0; // base-load set point
  localparam logic [SET_AW-1:0] S_LRATE  = 3'h1; // load step per tick
  localparam logic [SET_AW-1:0] S_URATE  = 3'h2; // unload step per tick
  localparam logic [SET_AW-1:0] S_TRIP   = 3'h3; // unload trip level
  localparam logic [SET_AW-1:0] S_ADJ    = 3'h4; // raise/lower target step
  localparam logic [SET_AW-1:0] S_PULSE  = 3'h5; // relay pulse ticks
  localparam logic [SET_AW-1:0] S_DROOP  = 3'h6; // droop gain /256

  // control bits
  localparam int CTRL_SAVE_BIT = 0;     // write one: save settings
  localparam int CTRL_UTIL_BIT = 1;     // relay held energised (utility)

  // ***********************************************
  // reset values and limits
  // ***********************************************
  localparam logic [LOAD_W-1:0] SET_RST     = 16'h0000;
  localparam logic [LOAD_W-1:0] EXT_MIN     = 16'h0333; // 1/80 of full scale, 0.25 mA on 0-20 mA
  localparam logic [LOAD_W-1:0] LOAD_MAX    = 16'hFFFF;
  localparam logic [LOAD_W-1:0] PULSE_RST   = 16'h0032; // default pulse ticks

  // contact vector positions
  localparam int C_BRK = 0;
  localparam int C_BASE = 1;
  localparam int C_UNL = 2;
  localparam int C_RAI = 3;
  localparam int C_LOW = 4;

  // load control modes, one-hot
  typedef enum logic [6:0] {
    M_DROOP  = 7'h01,  // breaker open
    M_SOFT   = 7'h02,  // soft loading into sharing
    M_SHARE  = 7'h04,  // isochronous sharing, ramps off
    M_BASE   = 7'h08,  // base load
    M_RETURN = 7'h10,  // ramp back to share level
    M_UNLOAD = 7'h20,  // ramp down to trip level
    M_TRIP   = 7'h40   // trip reached, pulse given
  } mode_type;

endpackage

/* hdl/setting_store.sv */
// Purpose: retained store of saved settings
// Assumes: contents survive presetn, which stands in for power removal
// Notes:   read data comes out of a register one cycle after the address
`timescale 1ns/1ps
module setting_store (
  input  wire logic                                   pclk,
  input  wire logic                                   we,
  input  wire logic [load_seq_pkg::SET_AW-1:0]        waddr,
  input  wire logic [load_seq_pkg::LOAD_W-1:0]        wdata,
  input  wire logic [load_seq_pkg::SET_AW-1:0]        raddr,
  output logic      [load_seq_pkg::LOAD_W-1:0]        rdata_r
);
  import load_seq_pkg::*;

  // ***********************************************
  // storage array, deliberately not reset
  // ***********************************************
  logic [LOAD_W-1:0] mem [0:SET_N-1];  // saved words

  // write port
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge pclk) begin
    rdata_r <= mem[raddr];
  end

endmodule

/* hdl/load_mode_sequencer.sv */
// Purpose: generator load mode sequencer with apb settings
// Assumes: contacts are asynchronous pins; load words share pclk
// Notes:   all mode and ramp changes happen on the control tick
`timescale 1ns/1ps
module load_mode_sequencer (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [load_seq_pkg::PAW-1:0]       paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata_r,
  output logic                                    pready_r,
  output logic                                    pslverr_r,
  input  wire logic                               breaker_closed_input,
  input  wire logic                               base_load_in,
  input  wire logic                               unload_in,
  input  wire logic                               raise_load_in,
  input  wire logic                               lower_load_in,
  input  wire logic [load_seq_pkg::LOAD_W-1:0]    ext_load_setting,
  input  wire logic [load_seq_pkg::LOAD_W-1:0]    system_share,
  input  wire logic [load_seq_pkg::LOAD_W-1:0]    unit_load,
  output logic      [load_seq_pkg::LOAD_W-1:0]    load_bias_r,
  output logic      [load_seq_pkg::LOAD_W-1:0]    droop_term_r,
  output logic                                    droop_active_r,
  output logic                                    breaker_open_relay_r
);
  import load_seq_pkg::*;

  // ***********************************************
  // helper functions
  // ***********************************************
  // setting index of an address, valid when in range
  function automatic logic [SET_AW-1:0] set_index(input logic [PAW-1:0] a);
    set_index = SET_AW'((a - SET0_OFS) >> 2);
  endfunction
  // address hits a setting word; higher addresses must not alias onto them
  function automatic logic is_set(input logic [PAW-1:0] a);
    is_set = (a >= SET0_OFS) && (a < SET0_OFS + PAW'(4 * SET_N)) && (a[1:0] == 2'b00);
  endfunction
  // one ramp step toward a target, never overshooting
  function automatic logic [LOAD_W-1:0] step_to(input logic [LOAD_W-1:0] cur, tgt, up, dn);
    if (cur < tgt) step_to = ((tgt - cur) > up) ? LOAD_W'(cur + up) : tgt;
    else step_to = ((cur - tgt) > dn) ? LOAD_W'(cur - dn) : tgt;
  endfunction

  // ***********************************************
  // contact synchronisers and control tick
  // ***********************************************
  logic [4:0]        cont_s1_r;   // first stage, read by second only
  logic [4:0]        cont_s2_r;   // synchronised contacts
  logic [4:0]        cont_r;      // contacts latched on the tick
  logic [TICK_W-1:0] tick_cnt_r;  // control cycle counter
  logic              tick_r;      // one-cycle control tick
  // two-flop synchroniser for all contact pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_s1_r <= 5'h00;
      cont_s2_r <= 5'h00;
    end else begin
      cont_s1_r <= {lower_load_in, raise_load_in, unload_in, base_load_in, breaker_closed_input};
      cont_s2_r <= cont_s1_r;
    end
  end
  // periodic tick; contacts sampled only here, so one view per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
      cont_r     <= 5'h00;
    end else begin
      tick_r <= (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
      if (tick_cnt_r == TICK_W'(TICK_CYCLES - 1)) begin
        tick_cnt_r <= '0;
        cont_r     <= cont_s2_r;
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  // ***********************************************
  // settings, save and restore
  // ***********************************************
  logic [LOAD_W-1:0] set_r [0:SET_N-1]; // working settings
  logic              util_r;            // relay idles energised
  logic              busy_r;            // save or restore running
  logic              saving_r;          // direction of the copy
  logic [SET_AW-1:0] xfer_r;            // copy index
  logic              rd_vld_r;          // restore data arrives next
  logic [SET_AW-1:0] rd_idx_r;          // index of arriving word
  logic [LOAD_W-1:0] store_q;           // store read data
  logic              apb_wr;            // completed write
  logic              save_req;          // software asked to save
  assign apb_wr   = psel & penable & pready_r & pwrite;
  assign save_req = apb_wr & (paddr == CTRL_OFS) & pwdata[CTRL_SAVE_BIT];
  setting_store u_store (
    .pclk    (pclk),
    .we      (busy_r & saving_r),
    .waddr   (xfer_r),
    .wdata   (set_r[xfer_r]),
    .raddr   (xfer_r),
    .rdata_r (store_q)
  );
  // copy sequencer; restore runs from reset so unsaved edits are lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r   <= 1'b1;
      saving_r <= 1'b0;
      xfer_r   <= '0;
      rd_vld_r <= 1'b0;
      rd_idx_r <= '0;
    end else begin
      rd_vld_r <= busy_r & ~saving_r;
      rd_idx_r <= xfer_r;
      if (busy_r) begin
        if (xfer_r == SET_AW'(SET_N - 1)) begin
          busy_r <= 1'b0;
          xfer_r <= '0;
        end else begin
          xfer_r <= xfer_r + 1'b1;
        end
      end else if (save_req) begin
        busy_r   <= 1'b1;
        saving_r <= 1'b1;
      end
    end
  end
  // working settings: apb writes and restored words
  genvar gi;
  generate
    for (gi = 0; gi < SET_N; gi++) begin : g_set
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          set_r[gi] <= (gi == S_PULSE) ? PULSE_RST : SET_RST;
        end else if (rd_vld_r && rd_idx_r == SET_AW'(gi)) begin
          set_r[gi] <= store_q;
        end else if (apb_wr && is_set(paddr) && set_index(paddr) == SET_AW'(gi)) begin
          set_r[gi] <= pwdata[LOAD_W-1:0];
        end
      end
    end
  endgenerate
  // relay polarity choice for utility service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      util_r <= 1'b0;
    end else if (apb_wr && paddr == CTRL_OFS) begin
      util_r <= pwdata[CTRL_UTIL_BIT];
    end
  end

  // ***********************************************
  // mode sequencer and ramp
  // ***********************************************
  mode_type          mode_r;      // current load control mode
  logic [LOAD_W-1:0] load_ref_r;  // ramped unit load reference
  logic [LOAD_W-1:0] base_tgt_r;  // adjustable base target
  logic [LOAD_W-1:0] pulse_cnt_r; // relay pulse ticks left
  logic              pulsed_r;    // pulse already given this unload
  logic              brk;         // contacts as seen on the tick
  logic              base_c;
  logic              unl_c;
  logic              both_rl;
  logic [LOAD_W-1:0] base_use;    // base target actually followed
  assign brk     = cont_r[C_BRK];
  assign base_c  = cont_r[C_BASE];
  assign unl_c   = cont_r[C_UNL];
  assign both_rl = cont_r[C_RAI] & cont_r[C_LOW];
  // external setting wins only above its live-zero minimum
  assign base_use = (both_rl && ext_load_setting > EXT_MIN) ? ext_load_setting
                                                            : base_tgt_r;
  // mode transitions; switchgear only closes base when paralleled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= M_DROOP;
    end else if (tick_r && !busy_r) begin
      if (!brk) begin
        mode_r <= M_DROOP;
      end else begin
        case (mode_r)
          M_DROOP: begin
            // breaker just closed: mode contacts now count
            if (base_c && unl_c) begin
              mode_r <= M_BASE;
            end else if (unl_c) begin
              mode_r <= M_SOFT;
            end else begin
              mode_r <= M_UNLOAD;
            end
          end
          M_SOFT, M_SHARE, M_RETURN: begin
            if (!unl_c) begin
              mode_r <= M_UNLOAD;
            end else if (base_c) begin
              mode_r <= M_BASE;
            end else if (mode_r != M_SHARE && load_ref_r == system_share) begin
              mode_r <= M_SHARE;
            end
          end
          M_BASE: begin
            if (!unl_c) begin
              mode_r <= M_UNLOAD;
            end else if (!base_c) begin
              mode_r <= M_RETURN;
            end
          end
          M_UNLOAD: begin
            if (load_ref_r == set_r[S_TRIP]) begin
              mode_r <= M_TRIP;
            end
          end
          M_TRIP: begin
            // reclosing unload resumes loading without a new breaker cycle
            if (unl_c) begin
              mode_r <= base_c ? M_BASE : M_SOFT;
            end
          end
          default: mode_r <= M_DROOP;
        endcase
      end
    end
  end
  // load reference ramp, stepped once per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_ref_r <= '0;
    end else if (tick_r && !busy_r) begin
      case (mode_r)
        M_DROOP:  load_ref_r <= '0;
        M_SOFT:   load_ref_r <= step_to(load_ref_r, system_share, set_r[S_LRATE],
                                        set_r[S_LRATE]);
        M_SHARE:  load_ref_r <= system_share;  // ramps disabled
        M_BASE:   load_ref_r <= step_to(load_ref_r, base_use, set_r[S_LRATE],
                                        set_r[S_URATE]);
        M_RETURN: load_ref_r <= step_to(load_ref_r, system_share, set_r[S_LRATE],
                                        set_r[S_URATE]);
        M_UNLOAD: load_ref_r <= step_to(load_ref_r, set_r[S_TRIP], set_r[S_URATE],
                                        set_r[S_URATE]);
        M_TRIP:   load_ref_r <= set_r[S_TRIP];
        default:  load_ref_r <= '0;
      endcase
    end
  end

  // base target: raise/lower contacts step it, saturating at the ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_tgt_r <= SET_RST;
    end else if (busy_r || mode_r != M_BASE) begin
      base_tgt_r <= set_r[S_BASE];  // each entry starts from the setting
    end else if (tick_r && cont_r[C_RAI] && !cont_r[C_LOW]) begin
      base_tgt_r <= (LOAD_MAX - base_tgt_r > set_r[S_ADJ]) ?
                    LOAD_W'(base_tgt_r + set_r[S_ADJ]) : LOAD_MAX;
    end else if (tick_r && cont_r[C_LOW] && !cont_r[C_RAI]) begin
      base_tgt_r <= (base_tgt_r > set_r[S_ADJ]) ?
                    LOAD_W'(base_tgt_r - set_r[S_ADJ]) : '0;
    end
  end

  // ***********************************************
  // breaker-open relay pulse
  // ***********************************************
  // one pulse per unload; cleared on breaker open or when loading restarts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_r <= '0;
      pulsed_r    <= 1'b0;
    end else if (tick_r) begin
      if (mode_r == M_DROOP || mode_r == M_SOFT || mode_r == M_BASE) begin
        pulsed_r <= 1'b0;
      end
      if (mode_r == M_TRIP && !pulsed_r) begin
        pulse_cnt_r <= set_r[S_PULSE];
        pulsed_r    <= 1'b1;
      end else if (pulse_cnt_r != '0) begin
        pulse_cnt_r <= pulse_cnt_r - 1'b1;
      end
    end
  end

  // relay level: sharing energises, utility service drops out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      breaker_open_relay_r <= 1'b0;
    end else begin
      breaker_open_relay_r <= util_r ^ (pulse_cnt_r != '0);
    end
  end

  // ***********************************************
  // speed reference contributions
  // ***********************************************
  logic [2*LOAD_W-1:0] droop_prod;  // load times droop gain
  assign droop_prod = unit_load * set_r[S_DROOP];
  // droop term subtracts from speed as load rises; bias only when loading
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      droop_active_r <= 1'b1;
      droop_term_r   <= '0;
      load_bias_r    <= '0;
    end else begin
      droop_active_r <= (mode_r == M_DROOP);
      droop_term_r   <= (mode_r == M_DROOP) ? droop_prod[LOAD_W+7:8] : '0;
      load_bias_r    <= (mode_r == M_DROOP) ? '0 : load_ref_r;
    end
  end

  // ***********************************************
  // apb slave: no wait state, registered answer
  // ***********************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel & ~penable;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (is_set(paddr)) begin
          prdata_r <= {16'h0000, set_r[set_index(paddr)]};
        end else begin
          case (paddr)
            CTRL_OFS:   prdata_r <= {30'h0, util_r, 1'b0};
            STATUS_OFS: prdata_r <= {15'h0, busy_r, 3'h0, cont_r, 1'b0, mode_r};
            LREF_OFS:   prdata_r <= {16'h0000, load_ref_r};
            DROOP_OFS:  prdata_r <= {16'h0000, droop_term_r};
            default:    pslverr_r <= 1'b1;  // unmapped
          endcase
        end
      end
    end
  end

endmodule

/* verif/load_seq_checker.sv */
// Purpose: port-level checks of the load mode sequencer
// Assumes: single pclk domain, presetn async active low
// Notes:   bound to every load_mode_sequencer instance
`timescale 1ns/1ps
module load_seq_checker (
  input wire logic                            pclk,
  input wire logic                            presetn,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pready_r,
  input wire logic                            pslverr_r,
  input wire logic                            breaker_closed_input,
  input wire logic [load_seq_pkg::LOAD_W-1:0] load_bias_r,
  input wire logic [load_seq_pkg::LOAD_W-1:0] droop_term_r,
  input wire logic                            droop_active_r,
  input wire logic                            breaker_open_relay_r
);
  import load_seq_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ************************
  // bus handshake
  // ************************
  ready_after_setup_a: assert property (pready_r |-> $past(psel && !penable))
    else $error("ready without a setup cycle");
  err_with_ready_a: assert property (pslverr_r |-> pready_r) else $error("error outside access");
  ready_one_cycle_a: assert property (pready_r |=> !pready_r) else $error("ready held too long");
  // ************************
  // load outputs
  // ************************
  droop_no_bias_a: assert property (droop_active_r |-> load_bias_r == '0)
    else $error("load bias present in droop");
  term_only_droop_a: assert property (!droop_active_r |-> droop_term_r == '0)
    else $error("droop term outside droop");
  open_to_droop_a: assert property ($fell(breaker_closed_input) |->
    ##[1:320] droop_active_r) else $error("no droop after breaker opened");
  // relay pulse and bias only move on the control tick, 100 cycles apart
  relay_pulse_hold_a: assert property ($changed(breaker_open_relay_r) |=>
    $stable(breaker_open_relay_r)[*8]) else $error("relay glitch shorter than a tick");
  bias_tick_step_a: assert property ($changed(load_bias_r) |=> $stable(load_bias_r)[*8])
    else $error("load bias moved between ticks");
  cover property (droop_active_r ##1 !droop_active_r);
  cover property ($rose(breaker_open_relay_r));
  cover property (pslverr_r);
endmodule
bind load_mode_sequencer load_seq_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready_r(pready_r), .pslverr_r(pslverr_r), .load_bias_r(load_bias_r),
  .breaker_closed_input(breaker_closed_input), .droop_term_r(droop_term_r),
  .droop_active_r(droop_active_r), .breaker_open_relay_r(breaker_open_relay_r));

/* verif/switchgear_model.sv */
// Purpose: plant switchgear contacts and generator seen by the sequencer
// Assumes: bench commands change right after a rising edge
// Notes:   generator load follows the bias only while on line
`timescale 1ns/1ps
module switchgear_model (
  input wire logic                            pclk,
  input wire logic                            gen_closed,
  input wire logic                            tie_closed,
  input wire logic                            base_sw,
  input wire logic                            unload_sw,
  input wire logic                            raise_sw,
  input wire logic                            lower_sw,
  input wire logic [load_seq_pkg::LOAD_W-1:0] idle_load,
  input wire logic [load_seq_pkg::LOAD_W-1:0] load_bias,
  output logic                                breaker_closed_input,
  output logic                                base_load_in,
  output logic                                unload_in,
  output logic                                raise_load_in,
  output logic                                lower_load_in,
  output logic [load_seq_pkg::LOAD_W-1:0]     unit_load
);
  import load_seq_pkg::*;
  // contacts and generator load, one register stage
  always @(posedge pclk) begin
    breaker_closed_input <= gen_closed;                   // aux contact follows breaker
    base_load_in         <= base_sw & gen_closed & tie_closed; // series wiring
    unload_in            <= unload_sw;
    raise_load_in        <= raise_sw;
    lower_load_in        <= lower_sw;
    unit_load            <= gen_closed ? load_bias : idle_load; // off line: local load only
  end
endmodule

/* verif/load_mode_sequencer_tb_top.sv */
// Purpose: directed bench for the load mode sequencer
// Assumes: 100 MHz pclk, control tick every 100 cycles
// Notes:   settings saved once so that restore is defined
`timescale 1ns/1ps
module load_mode_sequencer_tb_top;
  import load_seq_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, re;
  logic [PAW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata_r, rq;
  logic pready_r, pslverr_r, droop_active_r, breaker_open_relay_r, relay_d = 0;
  logic breaker_closed_input, base_load_in, unload_in, raise_load_in, lower_load_in;
  logic gen_closed = 0, tie_closed = 0, base_sw = 0, unload_sw = 0, raise_sw = 0, lower_sw = 0;
  logic [LOAD_W-1:0] ext_load_setting = '0, system_share = 16'h0800, idle_load = 16'h0400;
  logic [LOAD_W-1:0] unit_load, load_bias_r, droop_term_r;
  logic [LOAD_W-1:0] sv [7] = '{16'h0600, 16'h0100, 16'h0100, 16'h0200, 16'h0100, 16'h0002, 16'h0080};
  int fails = 0, comparisons = 0, pulses = 0, hi_cycles = 0;
  always #5 pclk = ~pclk;
  load_mode_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .breaker_closed_input(breaker_closed_input),
    .base_load_in(base_load_in), .unload_in(unload_in), .raise_load_in(raise_load_in),
    .lower_load_in(lower_load_in), .ext_load_setting(ext_load_setting),
    .system_share(system_share), .unit_load(unit_load), .load_bias_r(load_bias_r),
    .droop_term_r(droop_term_r), .droop_active_r(droop_active_r),
    .breaker_open_relay_r(breaker_open_relay_r));
  switchgear_model gear_u (.pclk(pclk), .gen_closed(gen_closed), .tie_closed(tie_closed),
    .base_sw(base_sw), .unload_sw(unload_sw), .raise_sw(raise_sw), .lower_sw(lower_sw),
    .idle_load(idle_load), .load_bias(load_bias_r), .breaker_closed_input(breaker_closed_input),
    .base_load_in(base_load_in), .unload_in(unload_in), .raise_load_in(raise_load_in),
    .lower_load_in(lower_load_in), .unit_load(unit_load));
  // relay pulse count and width, idle level low
  always @(posedge pclk) begin
    relay_d <= breaker_open_relay_r;
    if (breaker_open_relay_r === 1'b1 && relay_d === 1'b0) pulses++;
    if (breaker_open_relay_r === 1'b1) hi_cycles++;
  end
  // ************************
  // bench tasks
  // ************************
  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; a missing pready is left to the watchdog
  task automatic apb(input logic wr, input logic [PAW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk);
    while (pready_r !== 1'b1);
    rq = prdata_r;
    re = pslverr_r;
    psel <= 0; penable <= 0;
  endtask
  task automatic mode(input logic [6:0] exp);
    apb(0, STATUS_OFS, 32'h0);
    chk("mode", 32'(rq[6:0]), 32'(exp));
  endtask
  task automatic ticks(input int n);
    repeat (n * TICK_CYCLES) @(posedge pclk);
  endtask
  // reset, then wait until the settings restore is over
  task automatic do_reset;
    @(posedge pclk) presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    do apb(0, STATUS_OFS, 32'h0);
    while (rq[16] !== 1'b0);  // busy flag sits in status bit 16
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    final_report;
  end
  // ************************
  // scenarios
  // ************************
  initial begin
    do_reset;
    mode(7'h01);
    apb(0, 8'h2C, 32'h0);
    chk("unmapped error", 32'(re), 32'h1);
    for (int i = 0; i < 7; i++) apb(1, SET0_OFS + 8'(4 * i), 32'(sv[i]));
    apb(1, CTRL_OFS, 32'h1);
    repeat (20) @(posedge pclk);
    apb(1, SET0_OFS, 32'h0111);
    do_reset;
    apb(0, SET0_OFS, 32'h0);
    chk("base after restore", rq, 32'h0600);
    apb(0, SET0_OFS + 8'h14, 32'h0);
    chk("pulse after restore", rq, 32'h0002);
    unload_sw <= 1; raise_sw <= 1;
    ticks(5);
    chk("droop term", 32'(droop_term_r), 32'h0200);
    mode(7'h01);
    raise_sw <= 0; gen_closed <= 1;
    ticks(5);
    mode(7'h02);
    ticks(15);
    mode(7'h04);
    chk("shared load", 32'(load_bias_r), 32'h0800);
    system_share <= 16'h0900; tie_closed <= 1; base_sw <= 1;
    ticks(15);
    mode(7'h08);
    chk("base load", 32'(load_bias_r), 32'h0600);
    raise_sw <= 1;
    ticks(3);
    raise_sw <= 0;
    ticks(10);
    chk("raised load", 32'(load_bias_r > 16'h0600), 32'h1);
    ext_load_setting <= 16'h0A00; raise_sw <= 1; lower_sw <= 1;
    ticks(15);
    chk("external load", 32'(load_bias_r), 32'h0A00);
    raise_sw <= 0; lower_sw <= 0; base_sw <= 0;
    ticks(20);
    mode(7'h04);
    chk("returned load", 32'(load_bias_r), 32'h0900);
    unload_sw <= 0;
    ticks(20);
    mode(7'h40);
    chk("trip load", 32'(load_bias_r), 32'h0200);
    chk("relay pulses", 32'(pulses), 32'h1);
    chk("relay width", 32'(hi_cycles), 32'(2 * TICK_CYCLES));
    gen_closed <= 0; tie_closed <= 0;
    ticks(5);
    mode(7'h01);
    chk("bias removed", 32'(load_bias_r), 32'h0);
    apb(1, CTRL_OFS, 32'h2);
    ticks(3);
    chk("utility relay idle", 32'(breaker_open_relay_r), 32'h1);
    final_report;
  end
endmodule
